/* iso_uframe_defs.vh */
// Field positions and encodings of the isochronous descriptor write-back
`ifndef ISO_UFRAME_DEFS_VH
`define ISO_UFRAME_DEFS_VH

`define UF_COUNT_W      12
`define UF_RESULT_W     3
`define UF_NUM          8
`define UF_IDX_W        3
`define UF_LAST         3'h7
// Active mask in result/mask word, bits 7..0
`define MASK_LSB        0
// Result fields: uframe n at 8 + 3n
`define RESULT_LSB      8
// Split count of uframe 2
`define UF2_HI_LSB      0
`define UF2_LO_LSB      56
`define UF2_HI_W        4
`define UF2_LO_W        8
// Count offsets: uframes 0,1 in word_b, 3..7 in word_a
`define UF0_CNT_LSB     6'h20
`define UF1_CNT_LSB     6'h2C
`define UF3_CNT_LSB     6'h04
`define UF4_CNT_LSB     6'h10
`define UF5_CNT_LSB     6'h1C
`define UF6_CNT_LSB     6'h28
`define UF7_CNT_LSB     6'h34
// Valid (active) and halt flags
`define FLAG_VALID      63
`define FLAG_HALT       62
// Frame selection: bits 7..3 compared, 2..0 ignored
`define FRAME_HI        7
`define FRAME_LO        3
// Result bits
`define RES_XACT_ERR    0
`define RES_BABBLE      1
`define RES_UNDERRUN    2
// Event bits
`define EV_UFRAME_DONE  0
`define EV_HALT         1
`define EV_RETIRED      2
`define EV_W            3
// Register indices
`define REG_CTRL        4'h0
`define REG_FRAME       4'h1
`define REG_MASK        4'h2
`define REG_RESULT      4'h3
`define REG_CNT_LO      4'h4
`define REG_CNT_HI      4'h5
`define REG_FLAGS       4'h6
`define REG_IRQ_STAT    4'h7
`define REG_IRQ_MASK    4'h8

`endif

/* iso_uframe_descriptor_writeback.v */
// Isochronous descriptor scheduling and per-microframe result write-back
//
// Functional notes
// - Store 12-bit received count per microframe if active bit set and frame matches.
// - Microframe 2 count split: high nibble word A bits 3..0, low byte word B 63..56.
// - Eight 3-bit result fields packed: uframe 7 at 31..29, uframe 0 at 10..8.
// - Result field written after that microframe transaction completes on the bus.
// - Result bit 0 transaction error, bit 1 babble IN, bit 2 underrun OUT.
// - On frame match, only microframes with active bit 1 are issued.
// - Software sets active bits; hardware clears each once processed.
// - Active flag is the valid flag, one and the same bit; the code keeps valid as a register apart from the active mask bits.
// - Single halt flag; set on endpoint stall, clears valid.
// - Valid cleared after whole descriptor executed or on fatal error.
//
// The register addresses and strobed register access were left to the implementer.
module iso_uframe_descriptor_writeback (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // Register port
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // Bus timing
  input  wire [4:0]  bus_frame,
  input  wire [2:0]  bus_uframe,
  input  wire        uframe_start,
  // Transaction engine
  input  wire        is_in_token,
  output reg         issue,
  output reg  [2:0]  issue_uframe,
  input  wire        xact_done,
  input  wire [11:0] xact_count,
  input  wire        xact_error,
  input  wire        xact_babble,
  input  wire        xact_underrun,
  input  wire        ep_stall,
  input  wire        fatal_error,
  // Interrupt
  output reg         irq
);

`include "iso_uframe_defs.vh"

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_WAIT = 3'b100;

  // ----------------------------------------------------------------
  // Descriptor state
  // ----------------------------------------------------------------
  reg  [63:0] word_a;    // uframe 2 high nibble, counts 3..7
  reg  [63:0] word_b;    // mask, results, counts 0,1, uframe 2 low byte
  reg         valid;
  reg         halt;
  reg  [7:0]  frame_sel;
  reg  [2:0]  state;
  reg  [2:0]  cur_uf;
  reg  [2:0]  irq_stat;
  reg  [2:0]  irq_mask;
  reg  [2:0]  ev;
  reg  [2:0]  next_irq_stat;
  reg  [2:0]  next_irq_mask;
  reg         next_irq;
  reg  [31:0] next_rdata;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Write strobe aimed at one register index
  function wr_hit;
    input       we;
    input [3:0] a;
    input [3:0] idx;
    begin
      wr_hit = we && a == idx;
    end
  endfunction

  // Bit offset of a 12-bit count inside word_a (uframes 3..7)
  function [5:0] cnt_lsb_a;
    input [2:0] uf;
    begin
      cnt_lsb_a = `UF3_CNT_LSB;
      case (uf)
        3'h3: cnt_lsb_a = `UF3_CNT_LSB;
        3'h4: cnt_lsb_a = `UF4_CNT_LSB;
        3'h5: cnt_lsb_a = `UF5_CNT_LSB;
        3'h6: cnt_lsb_a = `UF6_CNT_LSB;
        3'h7: cnt_lsb_a = `UF7_CNT_LSB;
        default: cnt_lsb_a = `UF3_CNT_LSB;
      endcase
    end
  endfunction

  // Bit offset of a 12-bit count inside word_b (uframes 0 and 1)
  function [5:0] cnt_lsb_b;
    input [2:0] uf;
    begin
      cnt_lsb_b = `UF0_CNT_LSB;
      case (uf)
        3'h1: cnt_lsb_b = `UF1_CNT_LSB;
        default: cnt_lsb_b = `UF0_CNT_LSB;
      endcase
    end
  endfunction

  // Read back the count of one microframe
  function [11:0] count_of;
    input [2:0]  uf;
    input [63:0] a;
    input [63:0] b;
    begin
      count_of = 12'h000;
      case (uf)
        3'h0, 3'h1: count_of = b[cnt_lsb_b(uf) +: `UF_COUNT_W];
        3'h2: count_of = {a[`UF2_HI_LSB +: `UF2_HI_W], b[`UF2_LO_LSB +: `UF2_LO_W]};
        default: count_of = a[cnt_lsb_a(uf) +: `UF_COUNT_W];
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Decoded inputs and register strobes
  // ----------------------------------------------------------------
  wire [7:0]  active_mask = word_b[`MASK_LSB +: `UF_NUM];
  wire        frame_hit   = frame_sel[`FRAME_HI:`FRAME_LO] == bus_frame;
  wire [2:0]  res_code    = {xact_underrun & ~is_in_token,
                             xact_babble & is_in_token,
                             xact_error};
  wire        idle        = state == ST_IDLE;
  wire        wr_ctrl     = wr_hit(wr, addr, `REG_CTRL);
  wire        wr_frame    = wr_hit(wr, addr, `REG_FRAME);
  wire        wr_mask     = wr_hit(wr, addr, `REG_MASK);
  wire        wr_irq_mask = wr_hit(wr, addr, `REG_IRQ_MASK);
  wire        wr_clr_stat = wr_hit(wr, addr, `REG_IRQ_STAT);

  // ----------------------------------------------------------------
  // Next interrupt state
  // ----------------------------------------------------------------
  always @*
  begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    // New events win over a write-one clear
    if (wr_clr_stat)
      next_irq_stat = irq_stat & ~wdata[`EV_W-1:0];
    next_irq_stat = next_irq_stat | ev;
    if (wr_irq_mask)
      next_irq_mask = wdata[`EV_W-1:0];
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // ----------------------------------------------------------------
  // Scheduler and write-back
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_a       <= 64'h0;
      word_b       <= 64'h0;
      valid        <= 1'b0;
      halt         <= 1'b0;
      frame_sel    <= 8'h00;
      state        <= ST_IDLE;
      cur_uf       <= 3'h0;
      issue        <= 1'b0;
      issue_uframe <= 3'h0;
      ev           <= 3'h0;
    end
    else
    begin
      issue <= 1'b0;
      ev    <= 3'h0;
      // Software side of the descriptor
      if (wr_ctrl)
      begin
        if (wdata[0])
        begin
          valid <= 1'b1;
          halt  <= 1'b0;
        end
      end
      if (wr_frame)
        frame_sel <= wdata[7:0];
      if (wr_mask)
        word_b[`MASK_LSB +: `UF_NUM] <= active_mask | wdata[`MASK_LSB +: `UF_NUM];
      case (state)
        ST_IDLE:
        begin
          if (uframe_start && valid && !halt && frame_hit
              && active_mask[bus_uframe])
          begin
            issue        <= 1'b1;
            issue_uframe <= bus_uframe;
            cur_uf       <= bus_uframe;
            state        <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (fatal_error)
          begin
            valid <= 1'b0;
            ev[`EV_RETIRED] <= 1'b1;
            state <= ST_IDLE;
          end
          else if (ep_stall)
          begin
            halt  <= 1'b1;
            valid <= 1'b0;
            ev[`EV_HALT] <= 1'b1;
            state <= ST_IDLE;
          end
          else if (xact_done)
          begin
            // Only the processed microframe is touched
            word_b[`RESULT_LSB + `UF_RESULT_W * cur_uf +: `UF_RESULT_W]
              <= res_code;
            word_b[`MASK_LSB + cur_uf] <= 1'b0;
            case (cur_uf)
              3'h0, 3'h1: word_b[cnt_lsb_b(cur_uf) +: `UF_COUNT_W] <= xact_count;
              3'h2:
              begin
                word_a[`UF2_HI_LSB +: `UF2_HI_W] <= xact_count[11:8];
                word_b[`UF2_LO_LSB +: `UF2_LO_W] <= xact_count[7:0];
              end
              default: word_a[cnt_lsb_a(cur_uf) +: `UF_COUNT_W] <= xact_count;
            endcase
            ev[`EV_UFRAME_DONE] <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // Retire when no active bit is left or the millisecond ended
          if (active_mask == 8'h00 || cur_uf == `UF_LAST)
          begin
            valid <= 1'b0;
            ev[`EV_RETIRED] <= 1'b1;
          end
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      irq      <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq      <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @*
  begin
    next_rdata = 32'h0;
    if (rd)
    begin
      // Count selector rides on the write data bus
      case (addr)
        `REG_CTRL:     next_rdata = {29'h0, idle, halt, valid};
        `REG_FRAME:    next_rdata = {24'h0, frame_sel};
        `REG_MASK:     next_rdata = {24'h0, active_mask};
        `REG_RESULT:   next_rdata = word_b[31:0];
        `REG_CNT_LO:   next_rdata = {20'h0, count_of(wdata[2:0], word_a, word_b)};
        `REG_CNT_HI:   next_rdata = word_a[63:32];
        `REG_FLAGS:    next_rdata = {valid, halt, 30'h0};
        `REG_IRQ_STAT: next_rdata = {29'h0, irq_stat};
        `REG_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        default:       next_rdata = 32'h0;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else
      rdata <= next_rdata;
  end

endmodule

/* iso_wb_props.sv */
// Concurrent checks on the descriptor write-back ports
`include "iso_uframe_defs.vh"
module iso_wb_props (
  // Clock and reset
  input logic        mclk,
  input logic        rst_n,
  // Register port
  input logic [3:0]  addr,
  input logic [31:0] wdata,
  input logic        wr,
  input logic        rd,
  input logic [31:0] rdata,
  // Scheduling and interrupt
  input logic [2:0]  bus_uframe,
  input logic        uframe_start,
  input logic        issue,
  input logic [2:0]  issue_uframe,
  input logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  ctrl_read_a: assert property (rd && addr == `REG_CTRL |=> rdata[31:3] == 29'h0)
    else $error("control read spare bits set");
  issue_pulse_a: assert property (issue |=> !issue [*3])
    else $error("issue too close");
  issue_cause_a: assert property (issue |-> $past(uframe_start))
    else $error("issue without microframe start");
  issue_index_a: assert property (issue |-> issue_uframe == $past(bus_uframe))
    else $error("issue index wrong");
  index_hold_a: assert property (!issue |-> $stable(issue_uframe))
    else $error("issue index moved");
  flags_clean_a: assert property (rd && addr == `REG_FLAGS |=> rdata[29:0] == 30'h0)
    else $error("flag word spare bits set");
  irq_masked_a: assert property (wr && addr == `REG_IRQ_MASK && wdata[2:0] == 3'h0 |=> ##1 !irq)
    else $error("masked interrupt high");
endmodule
bind iso_uframe_descriptor_writeback iso_wb_props iso_wb_props_i (.mclk, .rst_n, .addr,
  .wdata, .wr, .rd, .rdata, .bus_uframe, .uframe_start, .issue, .issue_uframe, .irq);

/* iso_engine_model.sv */
// Behavioural bus engine answering each issued transaction
module iso_engine_model (
  // Clock
  input  logic        mclk,
  // Request and answer
  input  logic        issue,
  input  logic [11:0] cnt,
  input  logic [2:0]  err,
  input  logic        stall,
  output logic        xact_done,
  output logic [11:0] xact_count,
  output logic [2:0]  xact_flags,
  output logic        ep_stall
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {xact_done, ep_stall, xact_flags, xact_count} = 17'h0;
    forever
    begin
      @(posedge mclk);
      if (issue)
      begin
        repeat (1 + cnt[1:0]) @(posedge mclk);
        xact_done <= !stall;
        ep_stall <= stall;
        xact_count <= cnt;
        xact_flags <= err;
        @(posedge mclk);
        {xact_done, ep_stall} <= 2'h0;
        xact_count <= ~cnt;
        xact_flags <= ~err;
      end
    end
  end
endmodule

/* tb.sv */
// Self-checking bench for the descriptor write-back block
`include "iso_uframe_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, wr, rd, ufs, tok, issue, irq, stall, done, stl;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, lf, res0, ex, g;
  logic [4:0]  fr;
  logic [2:0]  bu, iuf, xf, e;
  logic [11:0] cnt, xc;
  logic [7:0]  act;
  int          num_errors, checked, cyc, nis;
  iso_uframe_descriptor_writeback iso_uframe_descriptor_writeback_i (.mclk, .rst_n, .addr,
    .wdata, .wr, .rd, .rdata, .bus_frame(fr), .bus_uframe(bu), .uframe_start(ufs),
    .is_in_token(tok), .issue, .issue_uframe(iuf), .xact_done(done), .xact_count(xc),
    .xact_error(xf[0]), .xact_babble(xf[1]), .xact_underrun(xf[2]), .ep_stall(stl),
    .fatal_error(1'b0), .irq);
  iso_engine_model iso_engine_model_i (.mclk, .issue, .cnt, .err(e), .stall,
    .xact_done(done), .xact_count(xc), .xact_flags(xf), .ep_stall(stl));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [2:0] exp_res(input logic [2:0] f, input logic t);
    return t ? {1'b0, f[1:0]} : {f[2], 1'b0, f[0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] x);
    checked++;
    if (got !== x)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, x);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] w, output logic [31:0] v);
    addr <= a;
    wdata <= w;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
    @(posedge mclk);
  endtask
  task automatic run_uf(input logic [2:0] u);
    bu <= u;
    ufs <= 1'b1;
    @(posedge mclk);
    ufs <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  task automatic irq_chk(input logic x);
    repeat (2) @(posedge mclk);
    cmp({31'h0, irq}, {31'h0, x});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    nis += issue;
    if (cyc > 3000)
    begin
      num_errors++;
      $display("mismatch at %0t: run too long", $time);
      print_verdict();
    end
  end
  initial
  begin
    {rst_n, wr, rd, ufs, stall, tok} = 6'h0;
    {addr, wdata, fr, bu, e, cnt} = 59'h0;
    lf = 32'hCB2663C6;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < 3; k++)
    begin
      lf = lfsr(lf);
      act = (k == 0) ? 8'hFF : (lf[7:0] | 8'h81);
      tok <= lf[8];
      fr <= lf[20:16] ^ 5'h01;
      wreg(`REG_IRQ_MASK, 32'h7);
      wreg(`REG_FRAME, {24'h0, lf[20:16], lf[2:0]});
      rd_reg(`REG_RESULT, 32'h0, res0);
      wreg(`REG_MASK, {24'h0, act});
      wreg(`REG_CTRL, 32'h1);
      nis = 0;
      run_uf(3'h0);
      cmp(nis, 0);
      fr <= lf[20:16];
      ex = res0 & 32'hFFFFFF00;
      for (int u = 0; u < 8; u++)
      begin
        lf = lfsr(lf);
        cnt <= lf[11:0];
        e <= lf[14:12];
        if (act[u])
          ex[8 + 3 * u +: 3] = exp_res(lf[14:12], tok);
        run_uf(u[2:0]);
        rd_reg(`REG_CNT_LO, u, g);
        if (act[u])
          cmp(g & 32'hFFF, {20'h0, lf[11:0]});
      end
      cmp(nis, $countones(act));
      rd_reg(`REG_RESULT, 32'h0, g);
      cmp(g, ex);
      rd_reg(`REG_FLAGS, 32'h0, g);
      cmp(g[31:30], 2'h0);
      cmp({31'h0, irq}, 32'h1);
      wreg(`REG_IRQ_STAT, 32'h7);
      irq_chk(1'b0);
      $display("run %0d done", k);
    end
    wreg(`REG_IRQ_MASK, 32'h0);
    wreg(`REG_MASK, 32'h1);
    wreg(`REG_CTRL, 32'h1);
    stall <= 1'b1;
    run_uf(3'h0);
    stall <= 1'b0;
    rd_reg(`REG_FLAGS, 32'h0, g);
    cmp(g[31:30], 2'h1);
    irq_chk(1'b0);
    wreg(`REG_IRQ_MASK, 32'h2);
    irq_chk(1'b1);
    wreg(`REG_IRQ_STAT, 32'h2);
    irq_chk(1'b0);
    $display("stall run done");
    print_verdict();
  end
endmodule
